// file: src/bag_defs.svh
// Register offsets, reset values and timing counts for the brightness
// and alarm gating block. Definitions only; included by bare name.
`ifndef BAG_DEFS_SVH
`define BAG_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BAG_OFS_CTRL    8'h00
`define BAG_OFS_MANUAL  8'h04
`define BAG_OFS_DULL    8'h08
`define BAG_OFS_AHI     8'h0C
`define BAG_OFS_ALO     8'h10
`define BAG_OFS_DIM     8'h14
`define BAG_OFS_DMASK   8'h18
`define BAG_OFS_STAT    8'h1C
`define BAG_OFS_ALMREQ  8'h80
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define BAG_CTRL_AUTO   0
`define BAG_RST_AUTO    1'h1
`define BAG_RST_MANUAL  6'h3F
`define BAG_RST_DULL    6'h07
`define BAG_RST_AHI     6'h3F
`define BAG_RST_ALO     6'h07
`define BAG_RST_DIM     16'h0000
`define BAG_MAN_MIN     6'h01
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BAG_CLK_HZ      64'd50000000
`define BAG_MINUTE_S    64'd60
`define BAG_MINUTE_CYC  (`BAG_MINUTE_S * `BAG_CLK_HZ)
`endif

// file: src/bag_pkg.sv
// Types shared by the brightness and alarm gating block.
// Assumes the constants header is compiled alongside.
package bag_pkg;
    // Which source sets the display level
    typedef enum logic [1:0] {
        BAG_SRC_MANUAL,
        BAG_SRC_AUTO,
        BAG_SRC_DULL
    } bag_src_t;
    typedef logic [5:0] bag_level_t;  // 0 dimmest .. 63 brightest
endpackage

// file: src/bag_top.sv
// Display brightness selection, inactivity dim timer and remote-input
// gating of 32 time alarms. Assumes one 50 MHz clock, pins arriving
// asynchronously, and alarm timing logic on the same clock.
// Function
// R1: Four requirement flags held per time alarm.
// R2: Alarm starts only with required inputs active.
// R3: Required input changes switch alarm relays live.
// R4: Auto mode follows light sensor level.
// R5: Manual level 1 to 63, default 63.
// R6: Dull input selects dull level, default 7.
// R7: Auto never above high limit.
// R8: Auto never below low limit; if limits cross, high limit wins.
// R9: Dim timer zero means disabled.
// R10: Timer counts from press, expiry dulls.
// R11: Expiry within one minute of setting.
// R12: Any press restores brightness, restarts timer.
// R13: Own dim timer, no master control.
// R14: Dulling overrides manual and auto levels.
`timescale 1ns/1ps
`include "bag_defs.svh"

// ----------------------------------------------------------------------
// Two flip-flop synchroniser
// ----------------------------------------------------------------------
module bag_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;  // First stage, read only by q_o
    // Both stages clear on reset
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_ff <= '0;
            q_o     <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module bag_top #(
    parameter logic [31:0] MINUTE_CYCLES = 32'(`BAG_MINUTE_CYC)
) (
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                resetn_i,
    // Register port
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [31:0]         reg_rdata_o,
    // Pins: remote inputs, buttons, light sensor
    input  wire logic [3:0]          remote_in_i,
    input  wire logic                button_i,
    input  wire logic [5:0]          light_level_i,
    input  wire logic                sensor_fitted_i,
    // Alarm timing logic
    input  wire logic [31:0]         alarm_run_i,
    output logic      [31:0]         alarm_gate_o,
    // Display
    output bag_pkg::bag_level_t      brightness_o,
    output logic                     dull_active_o
);
    import bag_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [11:0] pins_s;      // Synchronised pin bundle
    logic [3:0]  rin_s;       // Remote inputs, active high
    logic        btn_s;       // Any front button held
    bag_level_t  light_s;     // Ambient level; may tear for one cycle
    logic        fitted_s;    // Sensor present
    bag_sync #(.WIDTH(12)) u_sync (
        .clk_i    (core_clk_i),
        .resetn_i (resetn_i),
        .d_i      ({sensor_fitted_i, light_level_i, button_i, remote_in_i}),
        .q_o      (pins_s)
    );
    assign rin_s    = pins_s[3:0];
    assign btn_s    = pins_s[4];
    assign light_s  = pins_s[10:5];
    assign fitted_s = pins_s[11];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic        auto_en_ff;          // auto_brightness_enable
    bag_level_t  man_ff;              // manual_brightness_level
    bag_level_t  dull_ff;             // Dull level
    bag_level_t  ahi_ff;              // auto_high_limit
    bag_level_t  alo_ff;              // auto_low_limit
    logic [15:0] dim_ff;              // Dim timer, minutes
    logic [3:0]  dmask_ff;            // Remote inputs used for dulling
    logic [3:0]  req_mem [0:31];      // Per-alarm required inputs
    logic [31:0] rdata_ff;
    logic        btn_d_ff;            // Button edge history
    logic [31:0] pre_ff;              // Minute prescaler
    logic [15:0] dim_cnt_ff;          // Whole minutes since last press
    logic        expired_ff;          // Dim timer has run out
    bag_level_t  bright_ff;
    logic        dull_act_ff;         // Dulling in force
    logic [31:0] gate_ff;

    // Write decode
    wire         wr_ctrl  = reg_wr_i && reg_addr_i == `BAG_OFS_CTRL;
    wire         wr_man   = reg_wr_i && reg_addr_i == `BAG_OFS_MANUAL;
    wire         wr_dull  = reg_wr_i && reg_addr_i == `BAG_OFS_DULL;
    wire         wr_ahi   = reg_wr_i && reg_addr_i == `BAG_OFS_AHI;
    wire         wr_alo   = reg_wr_i && reg_addr_i == `BAG_OFS_ALO;
    wire         wr_dim   = reg_wr_i && reg_addr_i == `BAG_OFS_DIM;
    wire         wr_dmask = reg_wr_i && reg_addr_i == `BAG_OFS_DMASK;
    wire         in_alm   = reg_addr_i[7] && reg_addr_i[1:0] == 2'h0;
    wire [4:0]   alm_idx  = reg_addr_i[6:2];
    // A manual write of zero is raised to the dimmest legal level
    wire [5:0]   man_wr   = (reg_wdata_i[5:0] < `BAG_MAN_MIN) ?
                            `BAG_MAN_MIN : reg_wdata_i[5:0];  // R5

    // Configuration registers
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            auto_en_ff <= `BAG_RST_AUTO;
            man_ff     <= `BAG_RST_MANUAL;  // R5
            dull_ff    <= `BAG_RST_DULL;    // R6
            ahi_ff     <= `BAG_RST_AHI;     // R7
            alo_ff     <= `BAG_RST_ALO;     // R8
            dim_ff     <= `BAG_RST_DIM;     // R9
            dmask_ff   <= 4'h0;
        end
        else
        begin
            if (wr_ctrl)  auto_en_ff <= reg_wdata_i[`BAG_CTRL_AUTO];
            if (wr_man)   man_ff     <= man_wr;
            if (wr_dull)  dull_ff    <= reg_wdata_i[5:0];
            if (wr_ahi)   ahi_ff     <= reg_wdata_i[5:0];
            if (wr_alo)   alo_ff     <= reg_wdata_i[5:0];
            if (wr_dim)   dim_ff     <= reg_wdata_i[15:0];
            if (wr_dmask) dmask_ff   <= reg_wdata_i[3:0];
        end
    end

    // Requirement flags, four per alarm; reset clears every demand
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 32; i++)
                req_mem[i] <= 4'h0;             // R1
        end
        else if (reg_wr_i && in_alm)
        begin
            req_mem[alm_idx] <= reg_wdata_i[3:0]; // R1
        end
    end

    // Read mux; unmapped addresses read zero
    wire [31:0] stat_w = {20'h0, rin_s, expired_ff, dull_act_ff,
                          bright_ff};
    wire [31:0] rd_mux =
        (reg_addr_i == `BAG_OFS_CTRL)   ? {31'h0, auto_en_ff} :
        (reg_addr_i == `BAG_OFS_MANUAL) ? {26'h0, man_ff}     :
        (reg_addr_i == `BAG_OFS_DULL)   ? {26'h0, dull_ff}    :
        (reg_addr_i == `BAG_OFS_AHI)    ? {26'h0, ahi_ff}     :
        (reg_addr_i == `BAG_OFS_ALO)    ? {26'h0, alo_ff}     :
        (reg_addr_i == `BAG_OFS_DIM)    ? {16'h0, dim_ff}     :
        (reg_addr_i == `BAG_OFS_DMASK)  ? {28'h0, dmask_ff}   :
        (reg_addr_i == `BAG_OFS_STAT)   ? stat_w              :
        in_alm                          ? {28'h0, req_mem[alm_idx]} :
                                          32'h0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_ff <= 32'h0;
        else
            rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
    end
    assign reg_rdata_o = rdata_ff;

    // ------------------------------------------------------------------
    // Dim timer
    // ------------------------------------------------------------------
    // Only this unit's own buttons restart it; no master input exists
    wire press     = btn_s && !btn_d_ff;                // R13
    wire min_tick  = (pre_ff == MINUTE_CYCLES - 32'h1);
    // Prescaler restarts on a press, so expiry lands within a cycle of
    // the programmed minutes, well inside the allowed minute of slack
    wire nxt_exp   = (dim_ff != 16'h0) && (dim_cnt_ff >= dim_ff); // R9 R11

    // Press edge, prescaler, minute count and expiry flag
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            btn_d_ff   <= 1'h0;
            pre_ff     <= 32'h0;
            dim_cnt_ff <= 16'h0;
            expired_ff <= 1'h0;
        end
        else
        begin
            btn_d_ff <= btn_s;
            if (press)
            begin
                pre_ff     <= 32'h0;          // R12
                dim_cnt_ff <= 16'h0;          // R12
                expired_ff <= 1'h0;           // R12
            end
            else
            begin
                pre_ff     <= min_tick ? 32'h0 : pre_ff + 32'h1;
                // Saturate so a long idle never wraps back to bright
                if (min_tick && dim_cnt_ff != 16'hFFFF)
                    dim_cnt_ff <= dim_cnt_ff + 16'h1;  // R10
                expired_ff <= nxt_exp;                 // R10
            end
        end
    end

    // ------------------------------------------------------------------
    // Brightness selection
    // ------------------------------------------------------------------
    wire        remote_dull = |(rin_s & dmask_ff);         // R6
    wire        dull_now    = remote_dull || expired_ff;   // R10
    wire        auto_now    = auto_en_ff && fitted_s;      // R4
    // High limit applied last, so it wins if limits are crossed
    wire [5:0]  lo_clip = (light_s < alo_ff) ? alo_ff : light_s; // R8
    wire [5:0]  auto_lv = (lo_clip > ahi_ff) ? ahi_ff : lo_clip; // R7
    bag_src_t   src;
    assign src = dull_now ? BAG_SRC_DULL :                  // R14
                 auto_now ? BAG_SRC_AUTO : BAG_SRC_MANUAL;
    bag_level_t nxt_bright;
    always_comb
    begin
        case (src)
            BAG_SRC_DULL:   nxt_bright = dull_ff;           // R6
            BAG_SRC_AUTO:   nxt_bright = auto_lv;           // R4
            BAG_SRC_MANUAL: nxt_bright = man_ff;
            default:        nxt_bright = man_ff;
        endcase
    end

    // ------------------------------------------------------------------
    // Alarm gating
    // ------------------------------------------------------------------
    // An alarm passes while every demanded input is active; sampling
    // this each cycle both qualifies the start and follows later edges
    logic [31:0] req_ok;
    always_comb
    begin
        for (int i = 0; i < 32; i++)
            req_ok[i] = (req_mem[i] & ~rin_s) == 4'h0;      // R2
    end
    wire [31:0] nxt_gate = alarm_run_i & req_ok;            // R2 R3

    // Output flops
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bright_ff   <= `BAG_RST_MANUAL;
            dull_act_ff <= 1'h0;
            gate_ff     <= 32'h0;
        end
        else
        begin
            bright_ff   <= nxt_bright;
            dull_act_ff <= dull_now;
            gate_ff     <= nxt_gate;                        // R3
        end
    end
    assign brightness_o  = bright_ff;
    assign dull_active_o = dull_act_ff;
    assign alarm_gate_o  = gate_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_press;
        press;
    endsequence
    sequence s_cleared;
        !expired_ff && dim_cnt_ff == 16'h0;
    endsequence

    a_manual_range: assert property (man_ff >= 6'h01) // R5
        else $error("manual level below one");
    a_auto_high: assert property ( // R7
        src == BAG_SRC_AUTO |=> brightness_o <= $past(ahi_ff))
        else $error("auto level above high limit");
    a_auto_low: assert property ( // R8
        src == BAG_SRC_AUTO && alo_ff <= ahi_ff
        |=> brightness_o >= $past(alo_ff))
        else $error("auto level below low limit");
    a_dull_wins: assert property ( // R14
        remote_dull |=> brightness_o == $past(dull_ff) && dull_active_o)
        else $error("dull level not shown while dulling");
    a_timer_off: assert property ( // R9
        dim_ff == 16'h0 && $past(dim_ff) == 16'h0 |-> !expired_ff)
        else $error("dim timer expired while disabled");
    a_press_clear: assert property (s_press |=> s_cleared) // R12
        else $error("press did not restart dim timer");
    a_expiry_time: assert property ( // R11
        $rose(expired_ff) |-> $past(dim_cnt_ff) >= $past(dim_ff))
        else $error("dim timer expired early");
    a_expiry_dulls: assert property ( // R10
        expired_ff |=> dull_active_o)
        else $error("expiry did not dull display");
    a_alarm_block: assert property ( // R2
        (req_mem[0] & ~rin_s) != 4'h0 |=> !alarm_gate_o[0])
        else $error("alarm passed without required input");
    a_alarm_follow: assert property ( // R3
        alarm_run_i[0] && req_ok[0] ##1 alarm_run_i[0] && !req_ok[0]
        |=> !alarm_gate_o[0] ##1 1'b1)
        else $error("alarm did not follow required input");
endmodule

// file: dv/bag_far_side.sv
// Far-side model: remote digital inputs, front buttons, light sensor.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module bag_far_side (
    // Clock
    input  wire logic       core_clk_i,
    // Pins toward the block
    output logic      [3:0] remote_in_o,
    output logic            button_o,
    output logic      [5:0] light_level_o,
    output logic            sensor_fitted_o
);
    // Contacts open, sensor fitted, mid ambient light at power up
    initial
    begin
        remote_in_o     = 4'h0;
        button_o        = 1'b0;
        light_level_o   = 6'h20;
        sensor_fitted_o = 1'b1;
    end
    // Remote contacts are plain levels
    task automatic set_remote(input logic [3:0] v);
        remote_in_o <= v;
    endtask
    // Light changes slowly; held far longer than the sync depth
    task automatic set_light(input logic [5:0] v);
        light_level_o <= v;
    endtask
    // Sensor presence strap; unplugging forces manual brightness
    task automatic set_fitted(input logic v);
        sensor_fitted_o <= v;
    endtask
    // Press held four cycles so the two-flop sync cannot miss it
    task automatic press();
        button_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        button_o <= 1'b0;
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the brightness and alarm gating block.
// Assumes bag_defs.svh on the include path; minute shortened to 16.
`timescale 1ns/1ps
`include "bag_defs.svh"
module testbench;
    import bag_pkg::*;
    localparam int MIN_CYC = 16;           // Simulated minute length
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk_i    = 1'b0;
    logic        resetn_i      = 1'b0;
    logic [7:0]  reg_addr_i    = 8'h00;
    logic [31:0] reg_wdata_i   = 32'h0;
    logic        reg_wr_i      = 1'b0;
    logic        reg_rd_i      = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [3:0]  remote_in_i;
    logic        button_i;
    logic [5:0]  light_level_i;
    logic        sensor_fitted_i;
    logic [31:0] alarm_run_i   = 32'h0;
    logic [31:0] alarm_gate_o;
    bag_level_t  brightness_o;
    logic        dull_active_o;
    int          mismatches    = 0;
    int          comparisons   = 0;
    // 50 MHz clock
    always #10 core_clk_i = ~core_clk_i;
    // Outputs copied mid-cycle, so a check made at a rising edge sees
    // the settled value and never races the flops that edge updates
    bag_level_t  bright_q;
    logic        dull_q;
    logic [31:0] gate_q;
    always @(negedge core_clk_i)
    begin
        bright_q <= brightness_o;
        dull_q   <= dull_active_o;
        gate_q   <= alarm_gate_o;
    end
    bag_top #(.MINUTE_CYCLES(32'(MIN_CYC))) bag_top_i (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .remote_in_i(remote_in_i),
        .button_i(button_i), .light_level_i(light_level_i),
        .sensor_fitted_i(sensor_fitted_i), .alarm_run_i(alarm_run_i),
        .alarm_gate_o(alarm_gate_o), .brightness_o(brightness_o),
        .dull_active_o(dull_active_o));
    bag_far_side bag_far_side_i (
        .core_clk_i(core_clk_i), .remote_in_o(remote_in_i),
        .button_o(button_i), .light_level_o(light_level_i),
        .sensor_fitted_o(sensor_fitted_i));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe edge
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0]  a [9] = '{`BAG_OFS_CTRL, `BAG_OFS_MANUAL,
            `BAG_OFS_DULL, `BAG_OFS_AHI, `BAG_OFS_ALO, `BAG_OFS_DIM,
            `BAG_OFS_DMASK, `BAG_OFS_ALMREQ, 8'h20};
        logic [31:0] e [9] = '{32'h1, 32'h3F, 32'h7, 32'h3F, 32'h7,
            32'h0, 32'h0, 32'h0, 32'h0};
        foreach (a[i])
            rd_chk(a[i], e[i]);
        cyc(6 * MIN_CYC);
        chk({31'h0, dull_q}, 32'h0);
        chk({26'h0, bright_q}, 32'h20);
    endtask
    task automatic t_manual();
        wr(`BAG_OFS_CTRL, 32'h0);
        wr(`BAG_OFS_MANUAL, 32'h0);
        rd_chk(`BAG_OFS_MANUAL, 32'h1);
        chk({26'h0, bright_q}, 32'h1);
        wr(`BAG_OFS_MANUAL, 32'h3F);
        cyc(2);
        chk({26'h0, bright_q}, 32'h3F);
    endtask
    task automatic t_auto();
        logic [5:0] lt [3] = '{6'h05, 6'h32, 6'h14};
        logic [5:0] ex [3] = '{6'h0A, 6'h28, 6'h14};
        wr(`BAG_OFS_CTRL, 32'h1);
        wr(`BAG_OFS_AHI, 32'h28);
        wr(`BAG_OFS_ALO, 32'h0A);
        foreach (lt[i])
        begin
            bag_far_side_i.set_light(lt[i]);
            cyc(6);
            chk({26'h0, bright_q}, {26'h0, ex[i]});
        end
        // No sensor: auto enable alone must fall back to manual
        bag_far_side_i.set_fitted(1'b0);
        cyc(6);
        chk({26'h0, bright_q}, 32'h3F);
        bag_far_side_i.set_fitted(1'b1);
        cyc(6);
        chk({26'h0, bright_q}, 32'h14);
    endtask
    task automatic t_remote_dull();
        wr(`BAG_OFS_DULL, 32'h3);
        wr(`BAG_OFS_DMASK, 32'h1);
        bag_far_side_i.set_remote(4'h1);
        cyc(6);
        chk({26'h0, bright_q}, 32'h3);
        chk({31'h0, dull_q}, 32'h1);
        rd_chk(`BAG_OFS_STAT, 32'h143);
        cyc(1);
        bag_far_side_i.set_remote(4'h0);
        cyc(6);
        chk({26'h0, bright_q}, 32'h14);
        wr(`BAG_OFS_DMASK, 32'h0);
    endtask
    task automatic t_dim_timer();
        int n;
        wr(`BAG_OFS_DIM, 32'h2);
        bag_far_side_i.press();
        // One minute in: too early to dim, even with a minute of slack
        cyc(MIN_CYC);
        chk({31'h0, dull_q}, 32'h0);
        // Must dim before three minutes plus pipeline have passed
        n = 0;
        while (dull_q !== 1'b1 && n < 2 * MIN_CYC + 4)
        begin
            cyc(1);
            n++;
        end
        chk({31'h0, dull_q}, 32'h1);
        if (dull_q !== 1'b1)
            conclude();
        chk({26'h0, bright_q}, 32'h3);
        bag_far_side_i.press();
        cyc(6);
        chk({31'h0, dull_q}, 32'h0);
        chk({26'h0, bright_q}, 32'h14);
        wr(`BAG_OFS_DIM, 32'h0);
    endtask
    task automatic t_alarm();
        wr(`BAG_OFS_ALMREQ, 32'h4);
        wr(`BAG_OFS_ALMREQ + 8'h7C, 32'h9);
        alarm_run_i <= 32'h8000_0003;
        cyc(3);
        chk(gate_q, 32'h2);
        bag_far_side_i.set_remote(4'h4);
        cyc(6);
        chk(gate_q, 32'h3);
        bag_far_side_i.set_remote(4'h9);
        cyc(6);
        chk(gate_q, 32'h8000_0002);
        alarm_run_i <= 32'h0;
        cyc(2);
        chk(gate_q, 32'h0);
    endtask
    // Main sequence
    initial
    begin
        cyc(12);
        resetn_i <= 1'b1;
        t_reset_values();
        t_manual();
        t_auto();
        t_remote_dull();
        t_dim_timer();
        t_alarm();
        conclude();
    end
endmodule
